/* File: verif/testbench.sv */
/*
 Self-checking bench of the gated timer over classic Wishbone.
 Assumes tg_pkg and the far-side model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin nCompared++; if ((g) !== (e)) begin nFail++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module testbench;
    logic clk_sys = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic gateCmd = 1'b0, ack, gPin, cap, tick, lvl, ovfIrq, gIrq;
    logic cmpEv, wake, slp = 1'b0, sawCmp = 1'b0;
    logic [7:0] adr = 8'h00, t0, t2, pm;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [15:0] cnt;
    int nFail = 0, nCompared = 0;
    initial forever #10 clk_sys = ~clk_sys;
    // One-cycle pulse, so it is caught as it stands
    always @(posedge clk_sys) if (cmpEv === 1'b1) sawCmp <= 1'b1;
    tg_far_model u_tg_far_model (.clk_sys(clk_sys), .arst_n(arst_n), .gateCmd(gateCmd),
        .gatePin(gPin), .capturePin(cap), .countTick(tick), .t0Value(t0),
        .t2Value(t2), .periodMatchValue(pm));
    tg_timer_gate u_tg_timer_gate (.clk_sys(clk_sys), .arst_n(arst_n), .clkEn(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .gatePin(gPin), .capturePin(cap), .countTick(tick), .t0Value(t0),
        .t2Value(t2), .periodMatchValue(pm), .sleepMode(slp),
        .gateLevelStatus(lvl), .overflowIrq(ovfIrq), .gateIrq(gIrq),
        .wakeUp(wake), .compareEvent(cmpEv), .countValue(cnt));
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_sys); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task report_and_stop;
        $display("compared %0d mismatches %0d", nCompared, nFail);
        if (nFail == 0 && nCompared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (5000) @(posedge clk_sys);
        nFail++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        bus(1'b0, tg_pkg::OFS_CTRL, 32'h0);
        `CHK("ctrl", 32'h0, q)
        bus(1'b1, tg_pkg::OFS_COUNT, 32'hfffe);
        bus(1'b1, tg_pkg::OFS_FLAGS, 32'h7);
        bus(1'b1, tg_pkg::OFS_CTRL, 32'h35);
        repeat (12) @(posedge clk_sys);
        `CHK("ovfIrq", 1'b1, ovfIrq)
        slp <= 1'b1;
        @(posedge clk_sys);
        `CHK("wake", 1'b1, wake)
        slp <= 1'b0;
        bus(1'b1, tg_pkg::OFS_CTRL, 32'h0);
        bus(1'b0, tg_pkg::OFS_FLAGS, 32'h0);
        `CHK("ovf flag", 1'b1, q[0])
        bus(1'b0, tg_pkg::OFS_COUNT, 32'h0);
        `CHK("wrap", 1'b1, q[15:0] < 16'h0010)
        // Gate from pin, active high, pin held low
        bus(1'b1, tg_pkg::OFS_GATE, 32'h3);
        bus(1'b1, tg_pkg::OFS_COUNT, 32'h1234);
        bus(1'b1, tg_pkg::OFS_CTRL, 32'h1);
        repeat (20) @(posedge clk_sys);
        bus(1'b0, tg_pkg::OFS_COUNT, 32'h0);
        `CHK("held", 16'h1234, q[15:0])
        gateCmd <= 1'b1;
        repeat (10) @(posedge clk_sys);
        bus(1'b0, tg_pkg::OFS_GATE, 32'h0);
        `CHK("level", 1'b1, q[tg_pkg::GATE_LEVEL_BIT])
        bus(1'b0, tg_pkg::OFS_COUNT, 32'h0);
        `CHK("open", 1'b1, q[15:0] > 16'h1234)
        // Gating off, low polarity: pin rise makes the level fall
        bus(1'b1, tg_pkg::OFS_CTRL, 32'h8);
        bus(1'b1, tg_pkg::OFS_GATE, 32'h0);
        gateCmd <= 1'b0;
        repeat (6) @(posedge clk_sys);
        bus(1'b1, tg_pkg::OFS_FLAGS, 32'h7);
        gateCmd <= 1'b1;
        repeat (6) @(posedge clk_sys);
        `CHK("gIrq", 1'b1, gIrq)
        bus(1'b0, tg_pkg::OFS_FLAGS, 32'h0);
        `CHK("gate flag", 1'b1, q[1])
        // Period match through toggle and single pulse: one full period, 5 ticks
        bus(1'b1, tg_pkg::OFS_GATE, 32'h8f);
        bus(1'b1, tg_pkg::OFS_COUNT, 32'h0);
        bus(1'b1, tg_pkg::OFS_CTRL, 32'h1);
        bus(1'b1, tg_pkg::OFS_GATE, 32'h9f);
        repeat (60) @(posedge clk_sys);
        bus(1'b0, tg_pkg::OFS_GATE, 32'h0);
        `CHK("arm", 1'b0, q[tg_pkg::GATE_ARM_BIT])
        `CHK("lvl", 1'b0, lvl)
        bus(1'b0, tg_pkg::OFS_COUNT, 32'h0);
        `CHK("one period", 16'h0005, q[15:0])
        `CHK("countValue", 16'h0005, cnt)
        bus(1'b1, tg_pkg::OFS_GATE, 32'h0);
        // Compare with special clear: pair acts as the period
        bus(1'b1, tg_pkg::OFS_CTRL, 32'h0);
        bus(1'b1, tg_pkg::OFS_COUNT, 32'h0);
        bus(1'b1, tg_pkg::OFS_CCP_PAIR, 32'h5);
        bus(1'b1, tg_pkg::OFS_CCP_CTRL, 32'h3);
        bus(1'b1, tg_pkg::OFS_FLAGS, 32'h7);
        bus(1'b1, tg_pkg::OFS_CTRL, 32'h1);
        repeat (40) @(posedge clk_sys);
        bus(1'b1, tg_pkg::OFS_CTRL, 32'h0);
        bus(1'b0, tg_pkg::OFS_COUNT, 32'h0);
        `CHK("period", 1'b1, q[15:0] <= 16'h0005)
        bus(1'b0, tg_pkg::OFS_FLAGS, 32'h0);
        `CHK("no ovf", 1'b0, q[0])
        `CHK("ccp flag", 1'b1, q[2])
        `CHK("cmp event", 1'b1, sawCmp)
        report_and_stop();
    end
endmodule : testbench

/* File: verif/tg_far_model.sv */
/*
 Far side of the gated timer: gate pin, count clock and sibling timers.
 Assumes gateCmd comes from the bench on clk_sys.
*/
`timescale 1ns/1ps
module tg_far_model #(
    parameter logic [7:0] MATCH = 8'h09
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic gateCmd,
    output logic gatePin,
    output logic capturePin,
    output logic countTick,
    output logic [7:0] t0Value,
    output logic [7:0] t2Value,
    output logic [7:0] periodMatchValue
);
    assign periodMatchValue = MATCH;
    assign capturePin = 1'b0;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            gatePin <= 1'b0;
            countTick <= 1'b0;
            t0Value <= 8'h00;
            t2Value <= 8'h00;
        end else begin
            gatePin <= gateCmd;
            // Every other cycle, so a stuck-high tick is told apart
            countTick <= ~countTick;
            t0Value <= t0Value + 8'h01;
            t2Value <= (t2Value == MATCH) ? 8'h00 : t2Value + 8'h01;
        end
    end
endmodule : tg_far_model

/* File: verilog/tg_event_pulse.sv */
/*
 One-cycle pulse when a sibling timer value newly reaches a target.
 Assumes the value comes from logic on clk_sys and steps by one.
*/
`timescale 1ns/1ps
module tg_event_pulse #(
    parameter bit WRAP_ONLY = 1'b0
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic [7:0] valueIn,
    input wire logic [7:0] target,
    output logic pulse
);
    logic [7:0] prev_r;
    logic [7:0] prev_nxt;

    always_comb begin
        prev_nxt = clkEn ? valueIn : prev_r;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prev_r <= 8'h00;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    // Wrap form needs the step from the complement of the target onto the target
    assign pulse = (valueIn == target) && (valueIn != prev_r)
                   && (!WRAP_ONLY || (prev_r == ~target));

    property p_pulse_cause;
        @(posedge clk_sys) disable iff (!arst_n)
        pulse |-> (valueIn == target) && (prev_r != target);
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without new match");

    property p_wrap_pulse;
        @(posedge clk_sys) disable iff (!arst_n)
        (WRAP_ONLY && $past(clkEn) && (valueIn == target) && ($past(valueIn) == ~target))
            |-> pulse;
    endproperty
    a_wrap_pulse: assert property (p_wrap_pulse) else $error("rollover gave no pulse");
endmodule : tg_event_pulse

/* File: verilog/tg_pkg.sv */
/*
 Shared constants and types of the gated 16-bit timer: register offsets,
 field positions, reset values and mode encodings.
 Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package tg_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_GATE = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0c;
    localparam logic [7:0] OFS_CCP_CTRL = 8'h10;
    localparam logic [7:0] OFS_CCP_PAIR = 8'h14;

    // Control register fields
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_SYNC_DIS_BIT = 1;
    localparam int CTRL_OVF_IE_BIT = 2;
    localparam int CTRL_GATE_IE_BIT = 3;
    localparam int CTRL_PERIPH_IE_BIT = 4;
    localparam int CTRL_GLOBAL_IE_BIT = 5;
    localparam int CTRL_W = 6;

    // Gate register fields
    localparam int GATE_MODE_BIT = 0;
    localparam int GATE_POL_BIT = 1;
    localparam int GATE_TOG_BIT = 2;
    localparam int GATE_SPM_BIT = 3;
    localparam int GATE_ARM_BIT = 4;
    localparam int GATE_LEVEL_BIT = 5;
    localparam int GATE_SRC_LSB = 6;
    localparam int GATE_CFG_W = 4;

    // Flag register fields, write one to clear
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_GATE_BIT = 1;
    localparam int FLAG_CCP_BIT = 2;

    // Reset values
    localparam logic [CTRL_W-1:0] RST_CTRL = 6'h00;
    localparam logic [GATE_CFG_W-1:0] RST_GATE_CFG = 4'h0;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] RST_CCP_PAIR = 16'h0000;

    // Eight-bit timer rolls over onto this value
    localparam logic [7:0] T0_WRAP_TARGET = 8'h00;

    typedef enum logic [1:0] {
        GSRC_PIN = 2'h0,
        GSRC_T0_OVF = 2'h1,
        GSRC_T2_MATCH = 2'h2,
        GSRC_RSVD = 2'h3
    } tg_gsrc_e;

    typedef enum logic [1:0] {
        CCP_OFF = 2'h0,
        CCP_CAPTURE = 2'h1,
        CCP_COMPARE = 2'h2,
        CCP_COMPARE_SPECIAL = 2'h3
    } tg_ccp_e;

    typedef enum logic [2:0] {
        SPM_IDLE = 3'b001,
        SPM_ARMED = 3'b010,
        SPM_OPEN = 3'b100
    } tg_spm_e;
endpackage : tg_pkg

/* File: verilog/tg_sync2.sv */
/*
 Two-flop synchroniser, one chain per bit.
 Assumes inputs are asynchronous levels; outputs are on clk_sys.
*/
`timescale 1ns/1ps
module tg_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    generate
        if (WIDTH < 1) begin : g_bad
            $error("tg_sync2 needs WIDTH of at least one");
        end
    endgenerate

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic stage1_r;
            logic stage2_r;
            logic stage1_nxt;
            logic stage2_nxt;
            always_comb begin
                stage1_nxt = clkEn ? asyncIn[i] : stage1_r;
                stage2_nxt = clkEn ? stage1_r : stage2_r;
            end
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    stage1_r <= 1'b0;
                    stage2_r <= 1'b0;
                end else begin
                    stage1_r <= stage1_nxt;
                    stage2_r <= stage2_nxt;
                end
            end
            assign syncOut[i] = stage2_r;
        end
    endgenerate
endmodule : tg_sync2

/* File: verilog/tg_timer_gate.sv */
/*
 Gated 16-bit incrementing counter with gate sources, toggle and
 single-pulse gating, overflow and gate event flags, sleep wake and the
 capture/compare time base, behind a classic Wishbone slave.
 Assumes countTick is a one-cycle pulse per selected count-clock rising
 edge from clk_sys logic; sibling timer values are on clk_sys; gatePin
 and capturePin are asynchronous pins.
*/
`timescale 1ns/1ps
// Functional notes
// - Gated counting advances only while gate input matches the polarity setting.
// - Gate source select: pin, 8-bit overflow, period match; code three reserved.
// - 8-bit timer rollover to zero makes a rising pulse for the gate.
// - Period timer reaching its match value makes a rising pulse for the gate.
// - Toggle mode flips a flip-flop on each incrementing gate edge.
// - Toggle flip-flop is held at zero while toggle enable is clear.
// - Single pulse: enable, then arm; counting opens at next incrementing edge.
// - Arm bit clears itself at the trailing edge of the gate pulse.
// - Once disarmed, no gate event advances the counter until rearmed.
// - Toggle plus single pulse together measure exactly one gate period.
// - Gate level status reads the gate value, valid with gating disabled.
// - Falling gate level sets the gate event flag; enable raises request.
// - Gate event flag works even while gating is disabled.
// - Counter wraps all ones to zero and sets the overflow flag.
// - Overflow request needs counter on, overflow, peripheral and global enables.
// - In sleep only asynchronous mode counts; overflow wakes the device.
// - Capture mode copies the counter into the capture/compare pair.
// - Compare mode fires when the pair equals the counter.
// - Special event clears the counter without setting the overflow flag.
// - A counter byte write beats a coincident special event clear.
// - Counter runs only when on; gate mode adds the gate condition.
// - Open gate counts on count-clock rising edge; closed gate holds.
module tg_timer_gate #(
    parameter int COUNT_W = 16
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic gatePin,
    input wire logic capturePin,
    input wire logic countTick,
    input wire logic [7:0] t0Value,
    input wire logic [7:0] t2Value,
    input wire logic [7:0] periodMatchValue,
    input wire logic sleepMode,
    output logic gateLevelStatus,
    output logic overflowIrq,
    output logic gateIrq,
    output logic wakeUp,
    output logic compareEvent,
    output logic [COUNT_W-1:0] countValue
);
    generate
        if ((COUNT_W % 8 != 0) || (COUNT_W < 8) || (COUNT_W > 32)) begin : g_bad
            $error("COUNT_W must be 8, 16, 24 or 32");
        end
    endgenerate

    localparam int NBYTES = COUNT_W / 8;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction : hit

    // Pins
    logic [1:0] pinSync;
    tg_sync2 #(.WIDTH(2)) u_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .asyncIn({capturePin, gatePin}),
        .syncOut(pinSync)
    );

    logic t0Pulse;
    logic t2Pulse;
    tg_event_pulse #(.WRAP_ONLY(1'b1)) u_t0 (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .valueIn(t0Value),
        .target(tg_pkg::T0_WRAP_TARGET),
        .pulse(t0Pulse)
    );
    tg_event_pulse #(.WRAP_ONLY(1'b0)) u_t2 (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .valueIn(t2Value),
        .target(periodMatchValue),
        .pulse(t2Pulse)
    );

    // State
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic [tg_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [tg_pkg::GATE_CFG_W-1:0] gateCfg_r, gateCfg_nxt;
    tg_pkg::tg_gsrc_e srcSel_r, srcSel_nxt;
    tg_pkg::tg_ccp_e ccpMode_r, ccpMode_nxt;
    tg_pkg::tg_spm_e spm_r, spm_nxt;
    logic arm_r, arm_nxt;
    logic togFf_r, togFf_nxt;
    logic polPrev_r, polPrev_nxt;
    logic gateTmpPrev_r, gateTmpPrev_nxt;
    logic gateLevel_r, gateLevel_nxt;
    logic ovfFlag_r, ovfFlag_nxt;
    logic gateFlag_r, gateFlag_nxt;
    logic ccpFlag_r, ccpFlag_nxt;
    logic [COUNT_W-1:0] count_r, count_nxt;
    logic [COUNT_W-1:0] ccpPair_r, ccpPair_nxt;
    logic matchPrev_r, matchPrev_nxt;
    logic capPrev_r, capPrev_nxt;
    logic cmpOut_r, cmpOut_nxt;

    // Decoded controls
    logic busAcc, busWr;
    logic counterOn, syncDisable, gateModeEn, gatePol, togEn, spmEn;
    logic selSig, polSig, polRise, gateTmp, gateRise, gateFall;
    logic incEn, countWr, match, cmpEvt, specialClr, capRise, ovfSet;

    assign counterOn = ctrl_r[tg_pkg::CTRL_ON_BIT];
    assign syncDisable = ctrl_r[tg_pkg::CTRL_SYNC_DIS_BIT];
    assign gateModeEn = gateCfg_r[tg_pkg::GATE_MODE_BIT];
    assign gatePol = gateCfg_r[tg_pkg::GATE_POL_BIT];
    assign togEn = gateCfg_r[tg_pkg::GATE_TOG_BIT];
    assign spmEn = gateCfg_r[tg_pkg::GATE_SPM_BIT];
    assign busAcc = wb_cyc_i && wb_stb_i && !ack_r;
    assign busWr = busAcc && wb_we_i;
    assign countWr = busWr && hit(wb_adr_i, tg_pkg::OFS_COUNT) && (|wb_sel_i[NBYTES-1:0]);

    // Gate path: source, polarity, toggle, single pulse
    always_comb begin
        unique case (srcSel_r)
            tg_pkg::GSRC_PIN: selSig = pinSync[0];
            tg_pkg::GSRC_T0_OVF: selSig = t0Pulse;
            tg_pkg::GSRC_T2_MATCH: selSig = t2Pulse;
            tg_pkg::GSRC_RSVD: selSig = 1'b0;
        endcase
        // Active-high after polarity so rising means incrementing
        polSig = gatePol ? selSig : ~selSig;
        polRise = polSig && !polPrev_r;
        togFf_nxt = togFf_r;
        if (!togEn) begin
            togFf_nxt = 1'b0;
        end else if (polRise) begin
            togFf_nxt = ~togFf_r;
        end
        gateTmp = togEn ? togFf_nxt : polSig;
        gateRise = gateTmp && !gateTmpPrev_r;
        spm_nxt = spm_r;
        if (!spmEn) begin
            spm_nxt = tg_pkg::SPM_IDLE;
        end else begin
            unique case (spm_r)
                tg_pkg::SPM_IDLE: if (arm_r) spm_nxt = tg_pkg::SPM_ARMED;
                tg_pkg::SPM_ARMED: begin
                    if (!arm_r) spm_nxt = tg_pkg::SPM_IDLE;
                    else if (gateRise) spm_nxt = tg_pkg::SPM_OPEN;
                end
                tg_pkg::SPM_OPEN: if (!gateTmp) spm_nxt = tg_pkg::SPM_IDLE;
                default: spm_nxt = tg_pkg::SPM_IDLE;
            endcase
        end
        gateLevel_nxt = spmEn ? (gateTmp && (spm_nxt == tg_pkg::SPM_OPEN)) : gateTmp;
        gateFall = gateLevel_r && !gateLevel_nxt;
        polPrev_nxt = polSig;
        gateTmpPrev_nxt = gateTmp;
    end

    // Counter, compare and capture
    always_comb begin
        incEn = counterOn && (!gateModeEn || gateLevel_r)
                && (!sleepMode || syncDisable) && countTick;
        match = ((ccpMode_r == tg_pkg::CCP_COMPARE) || (ccpMode_r == tg_pkg::CCP_COMPARE_SPECIAL))
                && (ccpPair_r == count_r);
        cmpEvt = match && !matchPrev_r;
        specialClr = cmpEvt && (ccpMode_r == tg_pkg::CCP_COMPARE_SPECIAL);
        capRise = pinSync[1] && !capPrev_r;
        count_nxt = count_r;
        ovfSet = 1'b0;
        if (specialClr) begin
            count_nxt = '0;
        end else if (incEn) begin
            count_nxt = count_r + 1'b1;
            ovfSet = &count_r;
        end
        if (countWr) begin
            ovfSet = 1'b0;
            for (int b = 0; b < NBYTES; b++) begin
                if (wb_sel_i[b]) count_nxt[b*8 +: 8] = wb_dat_i[b*8 +: 8];
            end
        end
        ccpPair_nxt = ccpPair_r;
        if (busWr && hit(wb_adr_i, tg_pkg::OFS_CCP_PAIR)) begin
            for (int b = 0; b < NBYTES; b++) begin
                if (wb_sel_i[b]) ccpPair_nxt[b*8 +: 8] = wb_dat_i[b*8 +: 8];
            end
        end
        // Hardware capture beats a coincident software write
        if (capRise && (ccpMode_r == tg_pkg::CCP_CAPTURE)) begin
            ccpPair_nxt = count_r;
        end
        matchPrev_nxt = match;
        capPrev_nxt = pinSync[1];
        cmpOut_nxt = cmpEvt;
    end

    // Register file
    always_comb begin
        ack_nxt = busAcc;
        dat_nxt = dat_r;
        ctrl_nxt = ctrl_r;
        gateCfg_nxt = gateCfg_r;
        srcSel_nxt = srcSel_r;
        ccpMode_nxt = ccpMode_r;
        arm_nxt = arm_r;
        ovfFlag_nxt = ovfFlag_r;
        gateFlag_nxt = gateFlag_r;
        ccpFlag_nxt = ccpFlag_r;
        if (busWr && wb_sel_i[0]) begin
            if (hit(wb_adr_i, tg_pkg::OFS_CTRL)) begin
                ctrl_nxt = wb_dat_i[tg_pkg::CTRL_W-1:0];
            end
            if (hit(wb_adr_i, tg_pkg::OFS_GATE)) begin
                gateCfg_nxt = wb_dat_i[tg_pkg::GATE_CFG_W-1:0];
                srcSel_nxt = tg_pkg::tg_gsrc_e'(wb_dat_i[tg_pkg::GATE_SRC_LSB +: 2]);
                arm_nxt = wb_dat_i[tg_pkg::GATE_ARM_BIT];
            end
            if (hit(wb_adr_i, tg_pkg::OFS_FLAGS)) begin
                if (wb_dat_i[tg_pkg::FLAG_OVF_BIT]) ovfFlag_nxt = 1'b0;
                if (wb_dat_i[tg_pkg::FLAG_GATE_BIT]) gateFlag_nxt = 1'b0;
                if (wb_dat_i[tg_pkg::FLAG_CCP_BIT]) ccpFlag_nxt = 1'b0;
            end
            if (hit(wb_adr_i, tg_pkg::OFS_CCP_CTRL)) begin
                ccpMode_nxt = tg_pkg::tg_ccp_e'(wb_dat_i[1:0]);
            end
        end
        // Hardware sets come last so they win over clears
        if (spmEn && gateFall && !(busWr && wb_sel_i[0] && hit(wb_adr_i, tg_pkg::OFS_GATE)
                && wb_dat_i[tg_pkg::GATE_ARM_BIT])) begin
            arm_nxt = 1'b0;
        end
        if (ovfSet) ovfFlag_nxt = 1'b1;
        if (gateFall) gateFlag_nxt = 1'b1;
        if (cmpEvt || (capRise && (ccpMode_r == tg_pkg::CCP_CAPTURE))) ccpFlag_nxt = 1'b1;
        if (busAcc && !wb_we_i) begin
            dat_nxt = 32'h0000_0000;
            if (hit(wb_adr_i, tg_pkg::OFS_CTRL)) dat_nxt[tg_pkg::CTRL_W-1:0] = ctrl_r;
            if (hit(wb_adr_i, tg_pkg::OFS_GATE)) begin
                dat_nxt[tg_pkg::GATE_CFG_W-1:0] = gateCfg_r;
                dat_nxt[tg_pkg::GATE_ARM_BIT] = arm_r;
                dat_nxt[tg_pkg::GATE_LEVEL_BIT] = gateLevel_r;
                dat_nxt[tg_pkg::GATE_SRC_LSB +: 2] = srcSel_r;
            end
            if (hit(wb_adr_i, tg_pkg::OFS_FLAGS)) begin
                dat_nxt[tg_pkg::FLAG_OVF_BIT] = ovfFlag_r;
                dat_nxt[tg_pkg::FLAG_GATE_BIT] = gateFlag_r;
                dat_nxt[tg_pkg::FLAG_CCP_BIT] = ccpFlag_r;
            end
            if (hit(wb_adr_i, tg_pkg::OFS_COUNT)) dat_nxt[COUNT_W-1:0] = count_r;
            if (hit(wb_adr_i, tg_pkg::OFS_CCP_CTRL)) dat_nxt[1:0] = ccpMode_r;
            if (hit(wb_adr_i, tg_pkg::OFS_CCP_PAIR)) dat_nxt[COUNT_W-1:0] = ccpPair_r;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
            ctrl_r <= tg_pkg::RST_CTRL;
            gateCfg_r <= tg_pkg::RST_GATE_CFG;
            srcSel_r <= tg_pkg::GSRC_PIN;
            ccpMode_r <= tg_pkg::CCP_OFF;
            spm_r <= tg_pkg::SPM_IDLE;
            arm_r <= 1'b0;
            togFf_r <= 1'b0;
            polPrev_r <= 1'b0;
            gateTmpPrev_r <= 1'b0;
            gateLevel_r <= 1'b0;
            ovfFlag_r <= 1'b0;
            gateFlag_r <= 1'b0;
            ccpFlag_r <= 1'b0;
            count_r <= COUNT_W'(tg_pkg::RST_COUNT);
            ccpPair_r <= COUNT_W'(tg_pkg::RST_CCP_PAIR);
            matchPrev_r <= 1'b0;
            capPrev_r <= 1'b0;
            cmpOut_r <= 1'b0;
        end else if (clkEn) begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            ctrl_r <= ctrl_nxt;
            gateCfg_r <= gateCfg_nxt;
            srcSel_r <= srcSel_nxt;
            ccpMode_r <= ccpMode_nxt;
            spm_r <= spm_nxt;
            arm_r <= arm_nxt;
            togFf_r <= togFf_nxt;
            polPrev_r <= polPrev_nxt;
            gateTmpPrev_r <= gateTmpPrev_nxt;
            gateLevel_r <= gateLevel_nxt;
            ovfFlag_r <= ovfFlag_nxt;
            gateFlag_r <= gateFlag_nxt;
            ccpFlag_r <= ccpFlag_nxt;
            count_r <= count_nxt;
            ccpPair_r <= ccpPair_nxt;
            matchPrev_r <= matchPrev_nxt;
            capPrev_r <= capPrev_nxt;
            cmpOut_r <= cmpOut_nxt;
        end
    end

    // Outputs
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign gateLevelStatus = gateLevel_r;
    assign countValue = count_r;
    assign compareEvent = cmpOut_r;
    assign overflowIrq = ovfFlag_r && ctrl_r[tg_pkg::CTRL_OVF_IE_BIT] && counterOn
                         && ctrl_r[tg_pkg::CTRL_PERIPH_IE_BIT]
                         && ctrl_r[tg_pkg::CTRL_GLOBAL_IE_BIT];
    // Wake needs no global enable; vectoring is the core's choice
    assign wakeUp = sleepMode && ovfFlag_r && ctrl_r[tg_pkg::CTRL_OVF_IE_BIT] && counterOn
                    && ctrl_r[tg_pkg::CTRL_PERIPH_IE_BIT];
    assign gateIrq = gateFlag_r && ctrl_r[tg_pkg::CTRL_GATE_IE_BIT];

    // Checks
    sequence s_closed_gate;
        clkEn && gateModeEn && !gateLevel_r && !countWr && !specialClr;
    endsequence
    sequence s_spm_trail;
        clkEn && spmEn && arm_r && gateFall && !(busWr && hit(wb_adr_i, tg_pkg::OFS_GATE));
    endsequence

    property p_gate_hold;
        @(posedge clk_sys) disable iff (!arst_n)
        s_closed_gate |=> $stable(count_r);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("count moved with gate closed");

    property p_rsvd_src;
        @(posedge clk_sys) disable iff (!arst_n)
        (srcSel_r == tg_pkg::GSRC_RSVD) |-> !selSig;
    endproperty
    a_rsvd_src: assert property (p_rsvd_src) else $error("reserved source not quiet");

    property p_tog_clear;
        @(posedge clk_sys) disable iff (!arst_n)
        (clkEn && !togEn) |=> !togFf_r;
    endproperty
    a_tog_clear: assert property (p_tog_clear) else $error("toggle flop not held clear");

    property p_tog_flip;
        @(posedge clk_sys) disable iff (!arst_n)
        (clkEn && togEn && polRise) |=> (togFf_r != $past(togFf_r));
    endproperty
    a_tog_flip: assert property (p_tog_flip) else $error("toggle flop missed edge");

    property p_arm_clear;
        @(posedge clk_sys) disable iff (!arst_n)
        s_spm_trail |=> !arm_r ##1 (!gateLevel_r || arm_r);
    endproperty
    a_arm_clear: assert property (p_arm_clear) else $error("arm not cleared at trailing edge");

    property p_gate_flag;
        @(posedge clk_sys) disable iff (!arst_n)
        (clkEn && gateFall) |=> gateFlag_r && !gateLevel_r;
    endproperty
    a_gate_flag: assert property (p_gate_flag) else $error("gate flag not set on fall");

    property p_wrap;
        @(posedge clk_sys) disable iff (!arst_n)
        (clkEn && incEn && (&count_r) && !countWr && !specialClr)
            |=> (count_r == '0) && ovfFlag_r;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap without overflow flag");

    property p_special;
        @(posedge clk_sys) disable iff (!arst_n)
        (clkEn && specialClr && !countWr && !ovfFlag_r) |=> (count_r == '0) && !ovfFlag_r;
    endproperty
    a_special: assert property (p_special) else $error("special clear wrong");

    property p_write_wins;
        @(posedge clk_sys) disable iff (!arst_n)
        (clkEn && countWr && (&wb_sel_i[NBYTES-1:0])) |=> (count_r == $past(wb_dat_i[COUNT_W-1:0]));
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("counter write lost");

    property p_irq;
        @(posedge clk_sys) disable iff (!arst_n)
        overflowIrq |-> ovfFlag_r && counterOn && ctrl_r[tg_pkg::CTRL_GLOBAL_IE_BIT];
    endproperty
    a_irq: assert property (p_irq) else $error("overflow request without enables");

    property p_capture;
        @(posedge clk_sys) disable iff (!arst_n)
        (clkEn && capRise && (ccpMode_r == tg_pkg::CCP_CAPTURE)) |=> (ccpPair_r == $past(count_r));
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed counter value");
endmodule : tg_timer_gate
